/* File: design/hsio_pkg.sv */
/*
 Constants and types shared by the homing and I/O command handler.
 Assumes nine-byte binary frames, one clock and a synchronous reset.
*/
package hsio_pkg;
    // Instruction codes
    localparam logic [7:0] INSTR_HOMING   = 8'h0d;
    localparam logic [7:0] INSTR_SET_OUT  = 8'h0e;
    localparam logic [7:0] INSTR_READ     = 8'h0f;
    // Status byte of a good reply
    localparam logic [7:0] STATUS_OK      = 8'h64;
    // Homing request kinds
    localparam logic [7:0] HOME_START     = 8'h00;
    localparam logic [7:0] HOME_STOP      = 8'h01;
    localparam logic [7:0] HOME_STATUS    = 8'h02;
    // Banks and special ports
    localparam logic [7:0] BANK_INPUTS    = 8'h00;
    localparam logic [7:0] BANK_ANALOG    = 8'h01;
    localparam logic [7:0] BANK_OUTPUTS   = 8'h02;
    localparam logic [7:0] MOTOR_ZERO     = 8'h00;
    localparam logic [7:0] PORT_ALL       = 8'hff;
    localparam logic [7:0] PORT_ENC_ZERO  = 8'h0b;
    localparam logic [7:0] PORT_ANALOG    = 8'h00;
    localparam logic [7:0] PORT_TEMP      = 8'h09;
    localparam logic [7:0] NUM_OUTPUTS    = 8'h02;
    localparam logic [7:0] NUM_INPUTS     = 8'h04;
    localparam logic [31:0] VALUE_FROM_ACC = 32'hffffffff;
    localparam logic [31:0] VALUE_LEVEL_MAX = 32'h00000001;
    // Byte positions inside a frame
    localparam logic [3:0] POS_TARGET     = 4'h0;
    localparam logic [3:0] POS_INSTR      = 4'h1;
    localparam logic [3:0] POS_KIND       = 4'h2;
    localparam logic [3:0] POS_BANK       = 4'h3;
    localparam logic [3:0] POS_CHECKSUM   = 4'h8;
    // Addresses; values are arbitrary
    localparam logic [7:0] OWN_ADDR       = 8'h01;
    localparam logic [7:0] HOST_ADDR      = 8'h02;
    // Controller states
    typedef enum logic [2:0] {
        HS_IDLE = 3'b001,
        HS_EXEC = 3'b010,
        HS_SEND = 3'b100
    } hsio_state_t;
endpackage : hsio_pkg

/* File: design/hsio_sync.sv */
/*
 Three-stage synchroniser for pin inputs, one stage set per bit.
 Assumes the inputs are asynchronous levels from pins.
*/
`timescale 1ns/1ns
module hsio_sync
    import hsio_pkg::*;
#(
    parameter int W = 5
)(
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] pinSync
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } hsio_sync_t;

    hsio_sync_t        r;
    hsio_sync_t        next_r;
    wire logic [W-1:0] settle;

    // Per bit: stage three is taken only once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            assign settle[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.q[i];
        end
    endgenerate

    // Shift chain; the settled level holds while the stages disagree
    always_comb
    begin
        next_r    = r;
        next_r.s1 = pinIn;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.q  = settle;
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign pinSync = r.q;
endmodule : hsio_sync

/* File: design/hsio_reply_tx.sv */
/*
 Reply serialiser: appends the checksum and sends nine bytes.
 Assumes the receiver accepts a byte when txValid and txReady are high.
*/
`timescale 1ns/1ns
module hsio_reply_tx
    import hsio_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        load,
    input  wire logic [63:0] header,
    input  wire logic        txReady,
    output logic      [7:0]  txData,
    output logic             txValid,
    output logic             busy
);
    typedef struct packed {
        logic [71:0] frame;
        logic [3:0]  count;
        logic        valid;
        logic        busy;
    } hsio_tx_t;

    hsio_tx_t r;
    hsio_tx_t next_r;

    // Load, then shift out one byte per accepted handshake
    always_comb
    begin
        logic [7:0] sum;
        sum    = 8'h00;
        next_r = r;
        for (int k = 0; k < 8; k++)
        begin
            sum = sum + header[k*8 +: 8];
        end
        if (load && !r.busy)
        begin
            next_r.frame = {header, sum};
            next_r.count = 4'h0;
            next_r.valid = 1'b1;
            next_r.busy  = 1'b1;
        end
        else if (r.valid && txReady)
        begin
            next_r.frame = {r.frame[63:0], 8'h00};
            next_r.count = r.count + 4'h1;
            if (r.count == POS_CHECKSUM)
            begin
                next_r.valid = 1'b0;
                next_r.busy  = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign txData  = r.frame[71:64];
    assign txValid = r.valid;
    assign busy    = r.busy;
endmodule : hsio_reply_tx

/* File: design/hsio_cmd_handler.sv */
/*
 Command handler for homing, set-output and read-port frames.
 Assumes bytes arrive on a same-clock valid/ready stream and replies
 leave on another; homing engine, converter and sensor are outside.
*/
// Behaviour
// - Instruction 13: start, stop or query homing
// - Status query: 0 idle, nonzero while searching
// - Start, stop, set, read reply status OK
// - Reply: host, target, status, instr, value, sum
// - Instruction 14 bank 2 drives indexed output
// - Two outputs, indices 0 and 1, 0/1
// - Port 255 sets all outputs from bits
// - Value -1 takes outputs from accumulator
// - Instruction 15 reads port in bank 0-2
// - Digital reads 0/1, analog 12-bit
// - Direct mode keeps accumulator except port 255 bank 0 (bits 7:0), standalone copies
// - Bank 0 has four inputs, two shared
// - Port 255 bank 0 loads all inputs
// - Port 11 bank 0 reports encoder zero
// - Bank 1: analog port 0, temperature 9
// - Output states readable through read command
// - Bank 2 ports 0/1 return output state
`timescale 1ns/1ns
module hsio_cmd_handler
    import hsio_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  rxData,
    input  wire logic        rxValid,
    output logic             rxReady,
    output logic [7:0]       txData,
    output logic             txValid,
    input  wire logic        txReady,
    input  wire logic        standaloneMode,
    input  wire logic        homingActive,
    output logic             homingStart,
    output logic             homingStop,
    input  wire logic [3:0]  gpPins,
    input  wire logic        encNearZeroPin,
    input  wire logic [11:0] analogIn,
    input  wire logic [7:0]  temperature,
    output logic             gp_output_a,
    output logic             gp_output_b,
    output logic [31:0]      accumulator
);
    typedef struct packed {
        hsio_state_t state;
        logic [3:0]  count;
        logic [7:0]  sum;
        logic [7:0]  target;
        logic [7:0]  instr;
        logic [7:0]  kind;
        logic [7:0]  bank;
        logic [31:0] value;
        logic [31:0] acc;
        logic [1:0]  outs;
        logic        start;
        logic        stop;
        logic        ready;
        logic        load;
        logic [31:0] replyVal;
    } hsio_core_t;

    hsio_core_t  r;
    hsio_core_t  next_r;
    logic [4:0]  pinSync;
    logic        txBusy;
    logic [31:0] readVal;
    logic        readKnown;

    // Pin inputs pass the synchroniser
    hsio_sync #(.W(5)) u_sync (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pinIn   ({encNearZeroPin, gpPins}),
        .pinSync (pinSync)
    );

    // Reply serialiser
    hsio_reply_tx u_tx (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .load    (r.load),
        .header  ({HOST_ADDR, OWN_ADDR, STATUS_OK, r.instr, r.replyVal}),
        .txReady (txReady),
        .txData  (txData),
        .txValid (txValid),
        .busy    (txBusy)
    );

    // Selected line for a read command
    always_comb
    begin
        readVal   = 32'h0;
        readKnown = 1'b1;
        if (r.bank == BANK_INPUTS && r.kind < NUM_INPUTS)
        begin
            readVal = {31'h0, pinSync[r.kind[1:0]]};
        end
        else if (r.bank == BANK_INPUTS && r.kind == PORT_ALL)
        begin
            readVal = {28'h0, pinSync[3:0]};
        end
        else if (r.bank == BANK_INPUTS && r.kind == PORT_ENC_ZERO)
        begin
            readVal = {31'h0, pinSync[4]};
        end
        else if (r.bank == BANK_ANALOG && r.kind == PORT_ANALOG)
        begin
            readVal = {20'h0, analogIn};
        end
        else if (r.bank == BANK_ANALOG && r.kind == PORT_TEMP)
        begin
            readVal = {{24{temperature[7]}}, temperature};
        end
        else if (r.bank == BANK_OUTPUTS && r.kind < NUM_OUTPUTS)
        begin
            readVal = {31'h0, r.outs[r.kind[0]]};
        end
        else
        begin
            readKnown = 1'b0;
        end
    end

    // Frame assembly, execution and reply sequencing
    always_comb
    begin
        next_r       = r;
        next_r.start = 1'b0;
        next_r.stop  = 1'b0;
        next_r.load  = 1'b0;
        case (r.state)
            HS_IDLE:
            begin
                if (rxValid && r.ready)
                begin
                    next_r.sum   = r.sum + rxData;
                    next_r.count = r.count + 4'h1;
                    case (r.count)
                        POS_TARGET: next_r.target = rxData;
                        POS_INSTR:  next_r.instr  = rxData;
                        POS_KIND:   next_r.kind   = rxData;
                        POS_BANK:   next_r.bank   = rxData;
                        POS_CHECKSUM:
                        begin
                            next_r.count = 4'h0;
                            next_r.sum   = 8'h00;
                            if (rxData == r.sum && r.target == OWN_ADDR)
                            begin
                                next_r.state = HS_EXEC;
                                next_r.ready = 1'b0;
                            end
                        end
                        default:    next_r.value  = {r.value[23:0], rxData};
                    endcase
                end
            end
            HS_EXEC:
            begin
                next_r.state    = HS_SEND;
                next_r.load     = 1'b1;
                next_r.replyVal = 32'h0;
                case (r.instr)
                    INSTR_HOMING:
                    begin
                        if (r.kind == HOME_START)
                        begin
                            next_r.start = 1'b1;
                        end
                        else if (r.kind == HOME_STOP)
                        begin
                            next_r.stop = 1'b1;
                        end
                        else if (r.kind == HOME_STATUS)
                        begin
                            next_r.replyVal = {31'h0, homingActive};
                        end
                        else
                        begin
                            next_r.state = HS_IDLE;
                            next_r.load  = 1'b0;
                            next_r.ready = 1'b1;
                        end
                    end
                    INSTR_SET_OUT:
                    begin
                        if (r.bank == BANK_OUTPUTS && r.kind < NUM_OUTPUTS
                            && r.value <= VALUE_LEVEL_MAX)
                        begin
                            next_r.outs[r.kind[0]] = r.value[0];
                        end
                        else if (r.bank == BANK_OUTPUTS && r.kind == PORT_ALL)
                        begin
                            if (r.value == VALUE_FROM_ACC)
                            begin
                                next_r.outs = r.acc[1:0];
                            end
                            else
                            begin
                                next_r.outs = r.value[1:0];
                            end
                        end
                    end
                    INSTR_READ:
                    begin
                        next_r.replyVal = readVal;
                        if (r.bank == BANK_INPUTS && r.kind == PORT_ALL)
                        begin
                            next_r.acc[7:0] = readVal[7:0];
                        end
                        else if (standaloneMode && readKnown)
                        begin
                            next_r.acc = readVal;
                        end
                    end
                    default:
                    begin
                        next_r.state = HS_IDLE;
                        next_r.load  = 1'b0;
                        next_r.ready = 1'b1;
                    end
                endcase
            end
            HS_SEND:
            begin
                if (!r.load && !txBusy)
                begin
                    next_r.state = HS_IDLE;
                    next_r.ready = 1'b1;
                end
            end
            default:
            begin
                next_r.state = HS_IDLE;
                next_r.ready = 1'b1;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            r       <= '0;
            r.state <= HS_IDLE;
            r.ready <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign rxReady     = r.ready;
    assign homingStart = r.start;
    assign homingStop  = r.stop;
    assign gp_output_a = r.outs[0];
    assign gp_output_b = r.outs[1];
    assign accumulator = r.acc;

    logic execNow;
    assign execNow = (r.state == HS_EXEC);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_home_start: assert property (
        execNow && r.instr == INSTR_HOMING && r.kind == HOME_START
        |=> homingStart && !homingStop ##1 !homingStart)
        else $error("homing start not pulsed");
    a_home_stop: assert property (
        execNow && r.instr == INSTR_HOMING && r.kind == HOME_STOP
        |=> homingStop && !homingStart)
        else $error("homing stop not pulsed");
    a_home_status: assert property (
        execNow && r.instr == INSTR_HOMING
        && r.kind == HOME_STATUS |=> (r.replyVal != 32'h0) == $past(homingActive))
        else $error("homing status value wrong");
    a_reply_first: assert property (
        r.load |=> txValid && txData == HOST_ADDR)
        else $error("reply does not open with host address");
    a_reply_second: assert property (
        r.load ##1 (txValid && txReady) |=> txValid && txData == OWN_ADDR)
        else $error("reply second byte not own address");
    a_set_single: assert property (
        execNow && r.instr == INSTR_SET_OUT
        && r.bank == BANK_OUTPUTS && r.kind == 8'h01 && r.value <= VALUE_LEVEL_MAX
        |=> gp_output_b == $past(r.value[0]) && $stable(gp_output_a))
        else $error("single output not set");
    a_set_all: assert property (
        execNow && r.instr == INSTR_SET_OUT && r.bank == BANK_OUTPUTS
        && r.kind == PORT_ALL && r.value != VALUE_FROM_ACC
        |=> {gp_output_b, gp_output_a} == $past(r.value[1:0]))
        else $error("all outputs not set from value");
    a_set_acc: assert property (
        execNow && r.instr == INSTR_SET_OUT && r.bank == BANK_OUTPUTS
        && r.kind == PORT_ALL && r.value == VALUE_FROM_ACC
        |=> {gp_output_b, gp_output_a} == $past(accumulator[1:0]))
        else $error("outputs not taken from accumulator");
    a_read_direct: assert property (
        execNow && r.instr == INSTR_READ && !standaloneMode
        && !(r.bank == BANK_INPUTS && r.kind == PORT_ALL) |=> $stable(accumulator))
        else $error("direct read changed accumulator");
    a_read_back: assert property (
        execNow && r.instr == INSTR_READ && r.bank == BANK_OUTPUTS
        && r.kind == 8'h00 |=> r.replyVal == {31'h0, gp_output_a})
        else $error("output read-back wrong");
    a_bad_sum: assert property (
        r.state == HS_IDLE && rxValid && rxReady
        && r.count == POS_CHECKSUM && rxData != r.sum |=> r.state == HS_IDLE)
        else $error("bad checksum frame executed");

    c_home_start: cover property (homingStart);
    c_set_all:    cover property (execNow && r.instr == INSTR_SET_OUT && r.kind == PORT_ALL);
    c_read_all:   cover property (execNow && r.instr == INSTR_READ && r.kind == PORT_ALL);
    c_reply_done: cover property ($fell(txBusy));
endmodule : hsio_cmd_handler

/* File: bench/hsio_host_model.sv */
/*
 Host controller model: sends command frames and collects replies.
 Assumes the handler's same-clock valid/ready byte streams.
*/
`timescale 1ns/1ns
module hsio_host_model (
    input  wire logic       clk_sys,
    input  wire logic       rxReady,
    input  wire logic [7:0] txData,
    input  wire logic       txValid,
    output logic      [7:0] rxData,
    output logic            rxValid,
    output logic            txReady
);
    logic slow;
    logic fault;

    // Idle lines at time zero
    initial
    begin
        rxData  = 8'h00;
        rxValid = 1'b0;
        txReady = 1'b0;
        slow    = 1'b0;
        fault   = 1'b0;
    end

    // One frame; sumFix spoils the checksum on purpose
    task automatic send_frame(input logic [63:0] head, input logic [7:0] sumFix);
        logic [71:0] frame;
        logic [7:0]  sum;
        int          w;
        sum = 8'h00;
        for (int n = 0; n < 8; n++)
            sum += head[63-8*n -: 8];
        frame = {head, sum ^ sumFix};
        @(posedge clk_sys);
        for (int n = 0; n < 9; n++)
        begin
            rxValid <= 1'b1;
            rxData  <= frame[71-8*n -: 8];
            w = 0;
            do
            begin
                @(posedge clk_sys);
                w++;
            end
            while (rxReady !== 1'b1 && w < 50);
            if (w >= 50)
                fault = 1'b1;
        end
        // Released line shows no stale byte
        rxValid <= 1'b0;
        rxData  <= ~frame[7:0];
    endtask : send_frame

    // Reply bytes; slow host accepts every other cycle
    task automatic get_reply(output logic [71:0] reply, output logic got, input int bound);
        int n;
        int w;
        n = 0;
        w = 0;
        reply = 72'h0;
        while (n < 9 && w < bound)
        begin
            txReady <= slow ? ~txReady : 1'b1;
            @(posedge clk_sys);
            w++;
            if (txValid === 1'b1 && txReady === 1'b1)
            begin
                reply[71-8*n -: 8] = txData;
                n++;
            end
        end
        txReady <= 1'b0;
        got = (n == 9);
    endtask : get_reply
endmodule : hsio_host_model

/* File: bench/homing_and_io_command_handler_test.sv */
/*
 Self-checking bench: table of command rows, then homing, accumulator,
 bad-frame and reset cases. Assumes hsio_pkg and the host model.
*/
`timescale 1ns/1ns
`define CHECK(gotV, expV) \
    begin \
        compares++; \
        if ((gotV) !== (expV)) \
        begin \
            n_mismatch++; \
            $display("mismatch at %0t: got %h expected %h", $time, gotV, expV); \
        end \
    end
module homing_and_io_command_handler_test
    import hsio_pkg::*;
;
    typedef struct packed {
        logic [7:0]  instr;
        logic [7:0]  kind;
        logic [7:0]  bank;
        logic [31:0] value;
        logic        chkVal;
        logic [31:0] expVal;
        logic [1:0]  expOut;
    } hsio_row_t;

    logic        clk_sys = 1'b0;
    logic        sys_rst, rxReady, txValid, txReady, rxValid;
    logic [7:0]  rxData, txData, temperature;
    logic        standaloneMode, homingActive, homingStart, homingStop;
    logic [3:0]  gpPins;
    logic        encNearZeroPin, gp_output_a, gp_output_b;
    logic [11:0] analogIn;
    logic [31:0] accumulator;
    logic [71:0] reply;
    logic        got;
    int          n_mismatch = 0;
    int          compares = 0;
    int          nStart = 0;
    int          nStop = 0;
    int          s;

    hsio_cmd_handler dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .rxData(rxData),
        .rxValid(rxValid), .rxReady(rxReady), .txData(txData), .txValid(txValid),
        .txReady(txReady), .standaloneMode(standaloneMode), .homingActive(homingActive),
        .homingStart(homingStart), .homingStop(homingStop), .gpPins(gpPins),
        .encNearZeroPin(encNearZeroPin), .analogIn(analogIn), .temperature(temperature),
        .gp_output_a(gp_output_a), .gp_output_b(gp_output_b), .accumulator(accumulator));

    hsio_host_model host (.clk_sys(clk_sys), .rxReady(rxReady), .txData(txData),
        .txValid(txValid), .rxData(rxData), .rxValid(rxValid), .txReady(txReady));

    // Clock and homing pulse counters
    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        nStart <= nStart + (homingStart === 1'b1);
        nStop  <= nStop + (homingStop === 1'b1);
    end

    // Watchdog
    initial
    begin
        repeat (50000) @(posedge clk_sys);
        n_mismatch++;
        conclude();
    end

    function automatic logic [63:0] cmd(logic [7:0] i, k, b, logic [31:0] v);
        return {OWN_ADDR, i, k, b, v};
    endfunction : cmd

    task automatic conclude;
        if (n_mismatch == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    // Good frame: reply header, checksum and send completion
    task automatic xfer(input logic [63:0] head);
        logic [7:0] sum;
        host.send_frame(head, 8'h00);
        host.get_reply(reply, got, 80);
        sum = 8'h00;
        for (int n = 1; n < 9; n++)
            sum += reply[71-8*n+8 -: 8];
        `CHECK(reply[71:40], {HOST_ADDR, OWN_ADDR, STATUS_OK, head[55:48]})
        `CHECK(reply[7:0], sum)
        `CHECK(host.fault, 1'b0)
        if (!got)
        begin
            n_mismatch++;
            conclude();
        end
    endtask : xfer

    // Frame that must be dropped
    task automatic no_reply(input logic [63:0] head, input logic [7:0] sumFix);
        host.send_frame(head, sumFix);
        host.get_reply(reply, got, 40);
        `CHECK(got, 1'b0)
    endtask : no_reply

    hsio_row_t rows [16] = '{
        '{INSTR_SET_OUT, 8'h00, BANK_OUTPUTS, 32'h1, 1'b0, 32'h0, 2'b01},
        '{INSTR_SET_OUT, 8'h01, BANK_OUTPUTS, 32'h1, 1'b0, 32'h0, 2'b11},
        '{INSTR_READ, 8'h00, BANK_OUTPUTS, 32'h0, 1'b1, 32'h1, 2'b11},
        '{INSTR_SET_OUT, 8'h00, BANK_OUTPUTS, 32'h0, 1'b0, 32'h0, 2'b10},
        '{INSTR_READ, 8'h00, BANK_OUTPUTS, 32'h0, 1'b1, 32'h0, 2'b10},
        '{INSTR_SET_OUT, 8'h00, BANK_OUTPUTS, 32'h2, 1'b0, 32'h0, 2'b10},
        '{INSTR_SET_OUT, PORT_ALL, BANK_OUTPUTS, 32'hfe, 1'b0, 32'h0, 2'b10},
        '{INSTR_SET_OUT, PORT_ALL, BANK_OUTPUTS, 32'h1, 1'b0, 32'h0, 2'b01},
        '{INSTR_READ, 8'h00, BANK_INPUTS, 32'h0, 1'b1, 32'h0, 2'b01},
        '{INSTR_READ, 8'h01, BANK_INPUTS, 32'hffffffff, 1'b1, 32'h1, 2'b01},
        '{INSTR_READ, 8'h02, BANK_INPUTS, 32'h0, 1'b1, 32'h0, 2'b01},
        '{INSTR_READ, 8'h03, BANK_INPUTS, 32'h0, 1'b1, 32'h1, 2'b01},
        '{INSTR_READ, PORT_ENC_ZERO, BANK_INPUTS, 32'h0, 1'b1, 32'h1, 2'b01},
        '{INSTR_READ, PORT_ANALOG, BANK_ANALOG, 32'h0, 1'b1, 32'h5a6, 2'b01},
        '{INSTR_READ, PORT_TEMP, BANK_ANALOG, 32'h0, 1'b1, 32'hffffffe7, 2'b01},
        '{INSTR_HOMING, HOME_STATUS, MOTOR_ZERO, 32'h0, 1'b1, 32'h0, 2'b01}
    };

    // Main sequence
    initial
    begin
        sys_rst = 1'b1;
        standaloneMode = 1'b0;
        homingActive = 1'b0;
        gpPins = 4'b1010;
        encNearZeroPin = 1'b1;
        analogIn = 12'h5a6;
        temperature = 8'he7;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        `CHECK({rxReady, txValid, gp_output_b, gp_output_a}, 4'b1000)
        `CHECK(accumulator, 32'h0)
        repeat (6) @(posedge clk_sys);
        foreach (rows[i])
        begin
            xfer(cmd(rows[i].instr, rows[i].kind, rows[i].bank, rows[i].value));
            if (rows[i].chkVal)
                `CHECK(reply[39:8], rows[i].expVal)
            `CHECK({gp_output_b, gp_output_a}, rows[i].expOut)
            `CHECK(accumulator, 32'h0)
        end
        // Homing start, stop and active status
        s = nStart;
        xfer(cmd(INSTR_HOMING, HOME_START, MOTOR_ZERO, 32'h0));
        `CHECK(nStart, s + 1)
        s = nStop;
        xfer(cmd(INSTR_HOMING, HOME_STOP, MOTOR_ZERO, 32'h0));
        `CHECK(nStop, s + 1)
        @(posedge clk_sys);
        homingActive <= 1'b1;
        xfer(cmd(INSTR_HOMING, HOME_STATUS, MOTOR_ZERO, 32'h0));
        `CHECK(reply[39:8] !== 32'h0, 1'b1)
        homingActive <= 1'b0;
        // Accumulator loads and output copy, slow host
        xfer(cmd(INSTR_READ, PORT_ALL, BANK_INPUTS, 32'h0));
        `CHECK(accumulator, 32'h0000000a)
        @(posedge clk_sys);
        standaloneMode <= 1'b1;
        host.slow = 1'b1;
        xfer(cmd(INSTR_READ, PORT_ANALOG, BANK_ANALOG, 32'h0));
        `CHECK(accumulator, 32'h000005a6)
        xfer(cmd(INSTR_SET_OUT, PORT_ALL, BANK_OUTPUTS, VALUE_FROM_ACC));
        `CHECK({gp_output_b, gp_output_a}, 2'b10)
        host.slow = 1'b0;
        // Dropped frames leave outputs alone
        no_reply(cmd(INSTR_SET_OUT, 8'h00, BANK_OUTPUTS, 32'h1), 8'h01);
        no_reply({8'h05, INSTR_SET_OUT, 8'h00, BANK_OUTPUTS, 32'h1}, 8'h00);
        no_reply(cmd(8'h10, 8'h00, BANK_OUTPUTS, 32'h1), 8'h00);
        no_reply(cmd(INSTR_HOMING, 8'h03, MOTOR_ZERO, 32'h0), 8'h00);
        `CHECK({gp_output_b, gp_output_a}, 2'b10)
        // Second reset in mid-run
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        `CHECK({gp_output_b, gp_output_a, accumulator}, 34'h0)
        xfer(cmd(INSTR_READ, 8'h01, BANK_OUTPUTS, 32'h0));
        `CHECK(reply[39:8], 32'h0)
        conclude();
    end
endmodule : homing_and_io_command_handler_test
